// *** aop_pkg.sv ***
package aop_pkg;
  localparam int unsigned RES_BITS     = 8;
  localparam logic [7:0]  CODE_ZERO    = 8'h00;
  localparam logic [7:0]  CODE_FULL    = 8'hff;
  localparam int unsigned IN_BITS      = 12;
  localparam int unsigned PIPE_STAGES  = 2;
  localparam int unsigned WARMUP_CYC   = 2;
  localparam int unsigned CLK_MHZ      = 100;
  localparam int unsigned CONV_DIV     = 4;
  typedef enum logic [1:0] {AOP_COLD, AOP_WARM, AOP_RUN} aop_state_t;
endpackage : aop_pkg

// *** aop_quantizer.sv ***
`timescale 1ns/10ps
`default_nettype none
module aop_quantizer #(
  parameter int unsigned IN_W  = aop_pkg::IN_BITS,
  parameter int unsigned OUT_W = aop_pkg::RES_BITS
) (
  input  wire logic [IN_W-1:0]  level,
  input  wire logic [IN_W-1:0]  ref_bottom_level,
  input  wire logic [IN_W-1:0]  ref_top_level,
  output logic      [OUT_W-1:0] code
);
  logic [IN_W-1:0]      span;
  logic [IN_W-1:0]      ofs;
  logic [IN_W+OUT_W:0]  prod;
  logic [IN_W+OUT_W:0]  quot;
  always_comb begin
    span = ref_top_level - ref_bottom_level;
    ofs  = level - ref_bottom_level;
    prod = {{(OUT_W+1){1'b0}}, ofs} << OUT_W;
    quot = (span == '0) ? '0 : prod / {{(OUT_W+1){1'b0}}, span};
    if (level <= ref_bottom_level) begin
      code = aop_pkg::CODE_ZERO; // see RULE9
    end else if (level >= ref_top_level) begin
      code = aop_pkg::CODE_FULL; // see RULE10
    end else if (quot > {{(IN_W+1){1'b0}}, aop_pkg::CODE_FULL}) begin
      code = aop_pkg::CODE_FULL;
    end else begin
      code = quot[OUT_W-1:0]; // see RULE13
    end
  end
endmodule : aop_quantizer
`default_nettype wire

// *** aop_top.sv ***
// Functional notes
// RULE1 - sample input on conversion clock falling edge
// RULE2 - result appears 2.5 cycles after acquisition
// RULE3 - new result word every clock cycle
// RULE4 - output updates after rising conversion edge
// RULE5 - converts continuously while clock runs
// RULE6 - output enable low drives data
// RULE7 - output enable high floats data
// RULE8 - eight-bit result across reference span
// RULE9 - below bottom reference gives all zeros
// RULE10 - above top reference gives all ones
// RULE11 - host supplies two clocks before use
// RULE12 - host keeps conversion rate at least 1 MHz
// RULE13 - unsigned binary, monotonic within span
`timescale 1ns/10ps
`default_nettype none
module aop_top #(
  parameter int unsigned IN_W  = aop_pkg::IN_BITS,
  parameter int unsigned OUT_W = aop_pkg::RES_BITS
) (
  input  wire logic             ref_clk,
  input  wire logic             reset,
  input  wire logic             conv_clk,
  input  wire logic             out_enable_n,
  input  wire logic [IN_W-1:0]  analog_level,
  input  wire logic [IN_W-1:0]  ref_bottom_level,
  input  wire logic [IN_W-1:0]  ref_top_level,
  output logic      [OUT_W-1:0] data_out,
  output logic      [OUT_W-1:0] data_oe,
  output logic                  ready
);
  //////////////////////////////////////////////////////////////////////////
  // input synchronisers
  logic [1:0]       cclk_sync_q;
  logic [1:0]       oen_sync_q;
  logic             cclk_prev_q;
  logic             fall_ev;
  logic             rise_ev;
  logic [OUT_W-1:0] code;
  logic [OUT_W-1:0] held_q;
  logic [OUT_W-1:0] pipe_q [aop_pkg::PIPE_STAGES];
  logic [1:0]       warm_cnt_q;
  aop_pkg::aop_state_t state_q;

  always_ff @(posedge ref_clk) begin
    cclk_sync_q <= {cclk_sync_q[0], conv_clk};
    oen_sync_q  <= {oen_sync_q[0], out_enable_n};
    cclk_prev_q <= cclk_sync_q[1];
  end

  assign fall_ev = cclk_prev_q & ~cclk_sync_q[1];
  assign rise_ev = ~cclk_prev_q & cclk_sync_q[1];

  //////////////////////////////////////////////////////////////////////////
  // quantiser
  aop_quantizer #(.IN_W(IN_W), .OUT_W(OUT_W)) aop_quantizer_inst (
    .level            (analog_level),
    .ref_bottom_level (ref_bottom_level),
    .ref_top_level    (ref_top_level),
    .code             (code)
  ); // see RULE8

  //////////////////////////////////////////////////////////////////////////
  // sample and pipeline
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      held_q <= '0;
    end else if (fall_ev) begin
      held_q <= code; // see RULE1
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      for (int i = 0; i < aop_pkg::PIPE_STAGES; i++) pipe_q[i] <= '0;
    end else if (rise_ev) begin
      pipe_q[0] <= held_q; // see RULE3
      for (int i = 1; i < aop_pkg::PIPE_STAGES; i++) pipe_q[i] <= pipe_q[i-1]; // see RULE2
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      data_out <= '0;
    end else if (rise_ev) begin
      data_out <= pipe_q[aop_pkg::PIPE_STAGES-1]; // see RULE4
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // output enable
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      data_oe <= '0;
    end else begin
      data_oe <= {OUT_W{~oen_sync_q[1]}}; // see RULE6 see RULE7
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // warm-up tracking, free running conversion
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      state_q    <= aop_pkg::AOP_COLD;
      warm_cnt_q <= '0;
      ready      <= 1'b0;
    end else begin
      case (state_q)
        aop_pkg::AOP_COLD: begin
          if (rise_ev) begin
            state_q    <= aop_pkg::AOP_WARM;
            warm_cnt_q <= 2'h1;
          end
        end
        aop_pkg::AOP_WARM: begin
          if (rise_ev) begin
            warm_cnt_q <= warm_cnt_q + 2'h1;
            if (32'(warm_cnt_q) + 1 >= aop_pkg::WARMUP_CYC + aop_pkg::PIPE_STAGES) begin
              state_q <= aop_pkg::AOP_RUN; // see RULE11
              ready   <= 1'b1;
            end
          end
        end
        aop_pkg::AOP_RUN: begin
          ready <= 1'b1; // see RULE5
        end
        default: begin
          state_q <= aop_pkg::AOP_COLD;
        end
      endcase
    end
  end
endmodule : aop_top
`default_nettype wire

// *** aop_top_asserts.sv ***
`timescale 1ns/10ps
`default_nettype none
module aop_top_asserts (
  input wire logic       ref_clk,
  input wire logic       reset,
  input wire logic       conv_clk,
  input wire logic       out_enable_n,
  input wire logic [7:0] data_out,
  input wire logic [7:0] data_oe,
  input wire logic       ready
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  a_drive_when_low: assert property (!out_enable_n [*4] |=> data_oe == 8'hff) else $error("no drive");
  a_float_when_high: assert property (out_enable_n [*4] |=> data_oe == 8'h00) else $error("drives");
  a_whole_word_oe: assert property (data_oe == 8'h00 || data_oe == 8'hff) else $error("split oe");
  a_update_on_rise: assert property ($changed(data_out) && !$past(reset) |-> conv_clk) else $error("late");
  a_hold_prev_word: assert property ($rose(conv_clk) |=> $stable(data_out) [*2]) else $error("hold");
  a_stop_freezes: assert property (!conv_clk [*8] |=> $stable(data_out)) else $error("no freeze");
  a_ready_stays: assert property (ready |=> ready) else $error("ready fell");
  a_reset_clears: assert property (disable iff (1'b0) reset |=> data_out == 8'h00 && data_oe == 8'h00 && !ready)
    else $error("reset");
endmodule : aop_top_asserts
`default_nettype wire

// *** aop_host_model.sv ***
`timescale 1ns/10ps
`default_nettype none
module aop_host_model (
  input  wire logic       ref_clk,
  input  wire logic       run,
  input  wire logic [7:0] pin,
  output logic            conv_clk,
  output logic      [7:0] word_q
);
  logic [2:0] cnt_q = 3'h0;
  initial conv_clk = 1'b0;
  // 6.25 MHz conversion clock, stops low when not running
  always @(posedge ref_clk) begin
    cnt_q <= cnt_q + 3'h1;
    if (cnt_q == 3'h7) conv_clk <= run & ~conv_clk;
  end
  always @(negedge conv_clk) word_q <= pin;
endmodule : aop_host_model
`default_nettype wire

// *** aop_top_bench.sv ***
`timescale 1ns/10ps
`default_nettype none
module aop_top_bench;
  logic ref_clk = 1'b0, reset = 1'b1, oe_n = 1'b0, run = 1'b0, rdy, conv;
  logic [11:0] lvl = 12'h000;
  logic [7:0]  d, oe, word;
  wire  [7:0]  pin;
  int          mismatches = 0, comparisons = 0;
  initial forever #5 ref_clk = ~ref_clk;
  for (genvar i = 0; i < 8; i++) assign pin[i] = oe[i] ? d[i] : 1'bz;
  aop_top aop_top_inst (.ref_clk, .reset, .conv_clk(conv), .out_enable_n(oe_n), .analog_level(lvl),
    .ref_bottom_level(12'h100), .ref_top_level(12'h500), .data_out(d), .data_oe(oe), .ready(rdy));
  aop_host_model aop_host_model_inst (.ref_clk, .run, .pin, .conv_clk(conv), .word_q(word));
  task automatic check(string name, logic [7:0] seen, logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic finish_test();
    $display("mismatches %0d comparisons %0d", mismatches, comparisons);
    if (mismatches == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : finish_test
  task automatic sweep();
    logic [11:0] lv [7] = '{12'h000, 12'h100, 12'h104, 12'h300, 12'h4fb, 12'h500, 12'hfff};
    logic [7:0]  cd [7] = '{8'h00, 8'h00, 8'h01, 8'h80, 8'hfe, 8'hff, 8'hff};
    for (int i = 0; i < 7; i++) begin
      lvl <= lv[i];
      repeat (80) @(posedge ref_clk);
      check("word", word, cd[i]);
    end
  endtask : sweep
  task automatic latency();
    @(negedge conv);
    @(posedge ref_clk) lvl <= 12'h200;
    repeat (2) @(posedge conv);
    repeat (6) @(posedge ref_clk);
    check("old word", d, 8'hff);
    @(posedge conv);
    repeat (6) @(posedge ref_clk);
    check("new word", d, 8'h40);
  endtask : latency
  task automatic enable();
    oe_n <= 1'b1;
    repeat (6) @(posedge ref_clk);
    check("pin off", pin, 8'hzz);
    oe_n <= 1'b0;
    repeat (6) @(posedge ref_clk);
    check("pin on", pin, 8'h40);
  endtask : enable
  task automatic stop();
    run <= 1'b0;
    repeat (40) @(posedge ref_clk);
    lvl <= 12'h000;
    repeat (100) @(posedge ref_clk);
    check("frozen", d, 8'h40);
    run <= 1'b1;
    repeat (90) @(posedge ref_clk);
    check("resumed", d, 8'h00);
    check("ready", {7'h00, rdy}, 8'h01);
  endtask : stop
  initial begin
    repeat (20000) @(posedge ref_clk);
    mismatches++;
    finish_test();
  end
  initial begin
    repeat (2) @(posedge ref_clk);
    check("reset word", d, 8'h00);
    reset <= 1'b0;
    run   <= 1'b1;
    sweep();
    latency();
    enable();
    stop();
    finish_test();
  end
endmodule : aop_top_bench
bind aop_top aop_top_asserts aop_top_asserts_inst (.ref_clk, .reset, .conv_clk, .out_enable_n,
  .data_out, .data_oe, .ready);
`default_nettype wire
